// >>> hw/drive_command_word_decoder.sv
// command word decoder with stop style, control method and filter settings
`timescale 1ns/100ps
`default_nettype none
`include "drive_cmd_regs.svh"
module drive_command_word_decoder (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // command word access
    input  wire drive_cmd_pkg::cmd_write_t  cmd_wr,
    input  wire drive_cmd_pkg::cmd_src_t    owner_src,
    output logic [15:0]                     serial_usb_command_word,
    output logic [15:0]                     drive_state_word,
    // configuration
    input  wire drive_cmd_pkg::drive_cfg_t  cfg,
    // discrete input run and direction requests
    input  wire logic                       discrete_inputs_run,
    input  wire logic                       discrete_inputs_fwd,
    input  wire logic                       discrete_inputs_sel,
    // drive conditions
    input  wire logic                       fault_latched,
    input  wire logic                       at_rest,
    input  wire logic                       power_flow_to_drive,
    input  wire logic                       undervoltage,
    input  wire logic                       alarm,
    // measurements
    input  wire logic signed [15:0]         total_current,
    input  wire logic signed [15:0]         active_current,
    input  wire logic signed [15:0]         slip_comp_raw,
    output logic signed [15:0]              total_current_filt,
    output logic signed [15:0]              active_current_filt,
    output logic signed [15:0]              slip_comp_out,
    // decoded actions
    output var drive_cmd_pkg::drive_ctl_t   ctl,
    output logic                            fault_reset
);
    import drive_cmd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]           cw;
        run_state_t            st;
        logic [`TICK_W-1:0]    div;
        logic                  tick;
        logic                  frst;
        logic                  regen;
        logic signed [15:0]    slip;
        drive_ctl_t            ctl;
    } dec_state_t;
    dec_state_t s_q, s_d;

    logic               run_req;
    logic               fwd_req;
    logic               enable_req;
    logic               coast_sel;
    logic signed [15:0] slip_filt;
    logic [13:0]        cur_tau;
    logic [13:0]        slip_tau;

    // clamp a time constant to its largest setting
    function automatic logic [13:0] clamp_tau(input logic [13:0] t);
        clamp_tau = (t > `TAU_MAX_MS) ? `TAU_MAX_MS : t;
    endfunction

    // a single command word bit, read unmasked; reserved positions are cleared at write
    function automatic logic cw_bit(input logic [15:0] w, input int b);
        cw_bit = w[b];
    endfunction

    // ------------------------------------------------------------
    // command selection
    // ------------------------------------------------------------
    // discrete inputs steer run and direction only in local mode
    always_comb begin
        coast_sel  = (cfg.stop_style_select == `STOP_COAST);
        enable_req = cw_bit(s_q.cw, `CW_ENABLE);
        if (discrete_inputs_sel && !cw_bit(s_q.cw, `CW_REMOTE)) begin
            run_req = discrete_inputs_run;
            fwd_req = discrete_inputs_fwd;
        end else begin
            run_req = cw_bit(s_q.cw, `CW_RUN);
            fwd_req = cw_bit(s_q.cw, `CW_FORWARD);
        end
    end

    assign cur_tau  = clamp_tau(cfg.current_filter_tau);
    assign slip_tau = clamp_tau(cfg.slip_filter_tau);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // millisecond tick for the filters
        s_d.tick = 1'b0;
        if (s_q.div == `TICK_W'(`TICK_CYCLES - 1)) begin
            s_d.div  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.div = s_q.div + `TICK_W'(1);
        end
        // only the owning serial, network or logic source may write; keypad never
        if (cmd_wr.valid && cmd_wr.src == owner_src && cmd_wr.src != SRC_LOCAL) begin
            s_d.cw = cmd_wr.data & `CW_WRITE_MASK;
        end
        // fault reset pulses once per write with bit7 set, only when faulted
        s_d.frst = cmd_wr.valid && cmd_wr.src == owner_src && cmd_wr.src != SRC_LOCAL
                   && cmd_wr.data[`CW_FAULT_RST] && fault_latched;
        // run sequencing
        unique case (s_q.st)
            ST_OFF: begin
                if (enable_req && run_req && !fault_latched && !s_q.ctl.config_error) begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!enable_req || fault_latched || s_q.ctl.config_error) begin
                    s_d.st = ST_OFF;
                end else if (!run_req) begin
                    s_d.st = coast_sel ? ST_OFF : ST_STOP;
                end
            end
            ST_STOP: begin
                if (!enable_req || fault_latched || coast_sel || at_rest) begin
                    s_d.st = ST_OFF;
                end else if (run_req) begin
                    s_d.st = ST_RUN;
                end
            end
        endcase
        s_d.regen = power_flow_to_drive;
        // decoded outputs, registered
        s_d.ctl.run_ramp         = (s_d.st == ST_RUN);
        s_d.ctl.decel_ramp       = (s_d.st == ST_STOP);
        s_d.ctl.coast            = (s_d.st == ST_OFF);
        s_d.ctl.power_on         = (s_d.st != ST_OFF);
        s_d.ctl.forward          = fwd_req;
        s_d.ctl.inching_function = cw_bit(s_d.cw, `CW_INCHING);
        s_d.ctl.remote           = cw_bit(s_d.cw, `CW_REMOTE);
        s_d.ctl.ramp_pair2       = cw_bit(s_d.cw, `CW_RAMP2);
        s_d.ctl.method_vf              = (cfg.motor_control_method == `METHOD_VF);
        s_d.ctl.method_qvf             = (cfg.motor_control_method == `METHOD_QVF);
        s_d.ctl.sensorless_vector_mode = (cfg.motor_control_method == `METHOD_SVC);
        s_d.ctl.config_error = !(s_d.ctl.method_vf || s_d.ctl.method_qvf
                                 || s_d.ctl.sensorless_vector_mode);
        // slip comp only in vector mode, and dropped in regen if disabled
        s_d.ctl.slip_comp_active = s_d.ctl.sensorless_vector_mode
                                   && !(s_q.regen && !cfg.regen_slip_comp_enable);
        s_d.slip = s_q.ctl.slip_comp_active ? slip_filt : 16'sh0000;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q            <= '0;
            s_q.cw         <= `CW_RESET;
            s_q.st         <= ST_OFF;
            s_q.ctl.coast  <= 1'b1;
            s_q.ctl.method_vf <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // filters: three time constants to settle
    // ------------------------------------------------------------
    meas_filter u_total_filt (
        .clk    (clk),
        .rst    (rst),
        .tick   (s_q.tick),
        .tau_ms (cur_tau),
        .din    (total_current),
        .dout   (total_current_filt)
    );
    meas_filter u_active_filt (
        .clk    (clk),
        .rst    (rst),
        .tick   (s_q.tick),
        .tau_ms (cur_tau),
        .din    (active_current),
        .dout   (active_current_filt)
    );
    meas_filter u_slip_filt (
        .clk    (clk),
        .rst    (rst),
        .tick   (s_q.tick),
        .tau_ms (slip_tau),
        .din    (slip_comp_raw),
        .dout   (slip_filt)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every source sees the word read-only here
    assign serial_usb_command_word = s_q.cw;
    assign ctl           = s_q.ctl;
    assign fault_reset   = s_q.frst;
    assign slip_comp_out = s_q.slip;
    // status word assembled from registered state plus the live alarm, undervoltage and fault inputs
    always_comb begin
        drive_state_word               = 16'h0000;
        drive_state_word[`SW_RAMP2]    = s_q.ctl.ramp_pair2;
        drive_state_word[`SW_CONFIG]   = s_q.ctl.config_error;
        drive_state_word[`SW_ALARM]    = alarm;
        drive_state_word[`SW_RUNNING]  = s_q.ctl.power_on;
        drive_state_word[`SW_ENABLED]  = cw_bit(s_q.cw, `CW_ENABLE);
        drive_state_word[`SW_FORWARD]  = s_q.ctl.forward;
        drive_state_word[`SW_INCHING]  = s_q.ctl.inching_function;
        drive_state_word[`SW_REMOTE]   = s_q.ctl.remote;
        drive_state_word[`SW_UNDERVOLT] = undervoltage;
        drive_state_word[`SW_FAULT]    = fault_latched;
    end
endmodule
`default_nettype wire

// >>> hw/drive_cmd_regs.svh
// constants of the drive command word decoder
// How it works
// - bit0 clear ramps motor to rest; set accelerates to the reference.
// - bit1 is general enable; clear removes motor power, set allows operation.
// - bit2 set turns with reference direction, clear turns opposite.
// - bit3 switches the inching function on or off.
// - bit4 selects remote mode when set, local mode when clear.
// - bit5 picks first ramp time pair when clear, second when set.
// - bit7 set clears a latched fault; otherwise no effect.
// - only the owning source writes the word; all others only read it.
// - stop style 0 ramps down on selected decel time; 1 lets motor coast.
// - with stop style 1, clearing bit0 coasts just like clearing bit1.
// - stop style applies to all sources, discrete run inputs included.
// - keypad and discrete inputs never write the command word.
// - control method 0 linear, 1 quadratic, 5 sensorless vector; 2-4 unused.
// - current measurements get first-order filter, tau up to 9.999 s, default 0.005 s.
// - slip compensation filtered, tau default 0.5 s.
// - in vector mode, regen slip comp stays when enable 1, suppressed when 0.
// - regeneration means power flowing from motor back into the drive.
// - status bit15 reads 1 while a fault is registered.
// - status bit12 reports remote 1, local 0, from command bit4.
`ifndef DRIVE_CMD_REGS_SVH
`define DRIVE_CMD_REGS_SVH
// ------------------------------------------------------------
// command word fields
// ------------------------------------------------------------
`define CW_RUN         0
`define CW_ENABLE      1
`define CW_FORWARD     2
`define CW_INCHING     3
`define CW_REMOTE      4
`define CW_RAMP2       5
`define CW_FAULT_RST   7
`define CW_WRITE_MASK  16'h00bf
`define CW_RESET       16'h0000
// ------------------------------------------------------------
// status word fields
// ------------------------------------------------------------
`define SW_RAMP2       5
`define SW_CONFIG      6
`define SW_RUNNING     8
`define SW_ENABLED     9
`define SW_FORWARD     10
`define SW_INCHING     11
`define SW_ALARM       7
`define SW_REMOTE      12
`define SW_UNDERVOLT   13
`define SW_FAULT       15
// ------------------------------------------------------------
// settings: codes, reset values, filter time constants in milliseconds, filter tick in microseconds
// ------------------------------------------------------------
`define STOP_RAMP      1'b0
`define STOP_COAST     1'b1
`define METHOD_VF      3'h0
`define METHOD_QVF     3'h1
`define METHOD_SVC     3'h5
`define REGEN_EN_RESET 1'b1
`define TAU_MAX_MS     14'h270f
`define CUR_TAU_RESET  14'h0005
`define SLIP_TAU_RESET 14'h01f4
`define CLK_HZ         25000000
`define TICK_US        1000
`define TICK_CYCLES    ((`CLK_HZ / 1000000) * `TICK_US)
`define TICK_W         15
`define MEAS_W         16
`define FILT_SHIFT     5
`endif

// >>> hw/drive_cmd_pkg.sv
// types of the drive command word decoder
package drive_cmd_pkg;
    // command source owning the word
    typedef enum logic [1:0] {SRC_SERIAL, SRC_NETWORK, SRC_LOGIC, SRC_LOCAL} cmd_src_t;
    // write request from a command source
    typedef struct packed {
        logic        valid;
        cmd_src_t    src;
        logic [15:0] data;
    } cmd_write_t;
    // configuration settings
    typedef struct packed {
        logic        stop_style_select;
        logic [2:0]  motor_control_method;
        logic [13:0] current_filter_tau;
        logic [13:0] slip_filter_tau;
        logic        regen_slip_comp_enable;
    } drive_cfg_t;
    // decoded drive actions
    typedef struct packed {
        logic run_ramp;
        logic decel_ramp;
        logic coast;
        logic power_on;
        logic forward;
        logic inching_function;
        logic remote;
        logic ramp_pair2;
        logic method_vf;
        logic method_qvf;
        logic sensorless_vector_mode;
        logic config_error;
        logic slip_comp_active;
    } drive_ctl_t;
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_STOP} run_state_t;
endpackage

// >>> hw/meas_filter.sv
// first-order low pass filter with programmable time constant
`timescale 1ns/100ps
`default_nettype none
`include "drive_cmd_regs.svh"
module meas_filter (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // timing
    input  wire logic                 tick,
    input  wire logic [13:0]          tau_ms,
    // data
    input  wire logic signed [`MEAS_W-1:0] din,
    output logic signed [`MEAS_W-1:0]      dout
);
    typedef struct packed {
        logic [13:0]               cnt;
        logic signed [`MEAS_W+`FILT_SHIFT-1:0] acc;
    } filt_state_t;
    filt_state_t s_q, s_d;
    logic signed [`MEAS_W+`FILT_SHIFT-1:0] err;
    // one step of acc += din - out (out moves 1/32 of the error) every tau/32 + 1 ms; tau 0 passes through
    always_comb begin
        s_d = s_q;
        err = (`MEAS_W+`FILT_SHIFT)'(din) - (`MEAS_W+`FILT_SHIFT)'(dout);
        if (tau_ms == 14'h0000) begin
            s_d.acc = (`MEAS_W+`FILT_SHIFT)'(din) <<< `FILT_SHIFT;
        end else if (tick) begin
            if (s_q.cnt >= (tau_ms >> `FILT_SHIFT)) begin
                s_d.cnt = 14'h0000;
                s_d.acc = s_q.acc + err;
            end else begin
                s_d.cnt = s_q.cnt + 14'h0001;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign dout = s_q.acc[`MEAS_W+`FILT_SHIFT-1:`FILT_SHIFT];
endmodule
`default_nettype wire

// >>> testbench/cmd_source_model.sv
// model of the command sources that write the command word
`timescale 1ns/100ps
`default_nettype none
module cmd_source_model (
    // clock
    input  wire logic                     clk,
    // write request towards the decoder
    output var drive_cmd_pkg::cmd_write_t cmd_wr
);
    import drive_cmd_pkg::*;
    initial cmd_wr = '0;
    // one-cycle write; data is inverted once released so stale data never looks valid
    task automatic send(input cmd_src_t src, input logic [15:0] data);
        @(negedge clk);
        cmd_wr <= '{valid: 1'h1, src: src, data: data};
        @(negedge clk);
        cmd_wr <= '{valid: 1'h0, src: src, data: ~data};
    endtask
endmodule
`default_nettype wire

// >>> testbench/drive_cmd_sva.sv
// assertions on the command word decoder ports
`timescale 1ns/100ps
`default_nettype none
module drive_cmd_sva (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // watched ports
    input  wire drive_cmd_pkg::cmd_write_t  cmd_wr,
    input  wire drive_cmd_pkg::cmd_src_t    owner_src,
    input  wire logic [15:0]                serial_usb_command_word,
    input  wire logic [15:0]                drive_state_word,
    input  wire drive_cmd_pkg::drive_cfg_t  cfg,
    input  wire logic                       fault_latched,
    input  wire logic                       power_flow_to_drive,
    input  wire drive_cmd_pkg::drive_ctl_t  ctl,
    input  wire logic                       fault_reset
);
    import drive_cmd_pkg::*;
    // accepted write: owner only, never the local panel
    logic acc;
    assign acc = cmd_wr.valid && cmd_wr.src == owner_src && cmd_wr.src != SRC_LOCAL;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_write;
        acc |=> serial_usb_command_word == ($past(cmd_wr.data) & 16'h00bf);
    endproperty
    a_write: assert property (p_write) else $error("word differs from masked write");
    property p_refused;
        cmd_wr.valid && !acc |=> $stable(serial_usb_command_word);
    endproperty
    a_refused: assert property (p_refused) else $error("foreign write changed word");
    property p_fault_bit;
        drive_state_word[15] == fault_latched;
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("fault status bit wrong");
    property p_fault_reset;
        acc && cmd_wr.data[7] |=> fault_reset == $past(fault_latched);
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault reset pulse wrong");
    property p_enable_off;
        (!serial_usb_command_word[1])[*3] |-> !ctl.power_on;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("power on while disabled");
    property p_decel;
        acc && !cmd_wr.data[0] && cmd_wr.data[1] && !cfg.stop_style_select && ctl.run_ramp
            |-> ##[1:2] ctl.decel_ramp;
    endproperty
    a_decel: assert property (p_decel) else $error("ramp stop missing");
    property p_coast;
        acc && !cmd_wr.data[0] && cfg.stop_style_select && ctl.run_ramp |-> ##[1:2] ctl.coast;
    endproperty
    a_coast: assert property (p_coast) else $error("coast stop missing");
    property p_method;
        $stable(cfg.motor_control_method) |-> {ctl.method_vf, ctl.method_qvf,
            ctl.sensorless_vector_mode} == {cfg.motor_control_method == 3'h0,
            cfg.motor_control_method == 3'h1, cfg.motor_control_method == 3'h5};
    endproperty
    a_method: assert property (p_method) else $error("control method decode wrong");
    property p_slip;
        (cfg.motor_control_method == 3'h5 && power_flow_to_drive
            && !cfg.regen_slip_comp_enable)[*3] |-> !ctl.slip_comp_active;
    endproperty
    a_slip: assert property (p_slip) else $error("slip comp kept in regen");
endmodule
bind drive_command_word_decoder drive_cmd_sva drive_cmd_sva_i (.clk(clk), .rst(rst),
    .cmd_wr(cmd_wr), .owner_src(owner_src), .serial_usb_command_word(serial_usb_command_word),
    .drive_state_word(drive_state_word), .cfg(cfg), .fault_latched(fault_latched),
    .power_flow_to_drive(power_flow_to_drive), .ctl(ctl), .fault_reset(fault_reset));
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the command word decoder
`timescale 1ns/100ps
`default_nettype none
module tb;
    import drive_cmd_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               clk, rst, fault_reset, fault_latched, at_rest, power_flow_to_drive;
    logic               discrete_inputs_run, discrete_inputs_fwd, discrete_inputs_sel;
    logic [15:0]        serial_usb_command_word, drive_state_word;
    logic signed [15:0] total_current, active_current, slip_comp_raw;
    logic signed [15:0] total_current_filt, active_current_filt, slip_comp_out;
    cmd_write_t         cmd_wr;
    cmd_src_t           owner_src;
    drive_cfg_t         cfg;
    drive_ctl_t         ctl;
    int                 num_errors, compares, cycles;
    logic [15:0]        pats [5] = '{16'h0003, 16'h0007, 16'h000b, 16'h0013, 16'hff63};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    cmd_source_model cmd_source_model_i (.clk(clk), .cmd_wr(cmd_wr));
    drive_command_word_decoder drive_command_word_decoder_i (.clk(clk), .rst(rst),
        .cmd_wr(cmd_wr), .owner_src(owner_src), .serial_usb_command_word(serial_usb_command_word),
        .drive_state_word(drive_state_word), .cfg(cfg), .discrete_inputs_run(discrete_inputs_run),
        .discrete_inputs_fwd(discrete_inputs_fwd), .discrete_inputs_sel(discrete_inputs_sel),
        .fault_latched(fault_latched), .at_rest(at_rest), .undervoltage(1'b0), .alarm(1'b0),
        .power_flow_to_drive(power_flow_to_drive), .total_current(total_current),
        .active_current(active_current), .slip_comp_raw(slip_comp_raw),
        .total_current_filt(total_current_filt), .active_current_filt(active_current_filt),
        .slip_comp_out(slip_comp_out), .ctl(ctl), .fault_reset(fault_reset));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input cmd_src_t s, input logic [15:0] d);
        cmd_source_model_i.send(s, d);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        owner_src = SRC_NETWORK;
        cfg = '{1'h0, 3'h0, 14'h0000, 14'h0000, 1'h1};
        {discrete_inputs_run, discrete_inputs_fwd, discrete_inputs_sel} = 3'h0;
        {fault_latched, power_flow_to_drive, at_rest} = 3'h1;
        total_current = 16'sh1234;
        active_current = 16'sh0567;
        slip_comp_raw = 16'sh0089;
        rst = 1'b1;
        cyc(20);
        rst = 1'b0;
        check(serial_usb_command_word, 16'h0000);
        $display("test reset done");
        // field decode; last pattern carries reserved bits
        foreach (pats[i]) begin
            wr(SRC_NETWORK, pats[i]);
            cyc(2);
            check(serial_usb_command_word, pats[i] & 16'h00bf);
            check({ctl.run_ramp, ctl.power_on}, 16'h0003);
            check({ctl.ramp_pair2, ctl.remote, ctl.inching_function, ctl.forward},
                  {12'h000, pats[i][5:2]});
            check({drive_state_word[12], drive_state_word[5]}, {pats[i][4], pats[i][5]});
        end
        $display("test fields done");
        // foreign sources, and the keypad even as owner, only read the word
        wr(SRC_SERIAL, 16'h0000);
        check(serial_usb_command_word, 16'h0023);
        owner_src = SRC_LOCAL;
        wr(SRC_LOCAL, 16'h0000);
        check(serial_usb_command_word, 16'h0023);
        owner_src = SRC_NETWORK;
        $display("test access done");
        // ramp stop holds decel until rest, then coast and disable stops
        at_rest = 1'b0;
        wr(SRC_NETWORK, 16'h0002);
        cyc(1);
        check({ctl.decel_ramp, ctl.coast}, 16'h0002);
        at_rest = 1'b1;
        cyc(2);
        check(ctl.run_ramp, 16'h0000);
        cfg.stop_style_select = 1'b1;
        wr(SRC_NETWORK, 16'h0003);
        cyc(2);
        wr(SRC_NETWORK, 16'h0002);
        cyc(1);
        check({ctl.coast, ctl.power_on}, 16'h0002);
        cfg.stop_style_select = 1'b0;
        wr(SRC_NETWORK, 16'h0003);
        cyc(2);
        wr(SRC_NETWORK, 16'h0001);
        cyc(1);
        check({ctl.coast, ctl.power_on}, 16'h0002);
        // discrete inputs also stop by coasting
        cfg.stop_style_select = 1'b1;
        wr(SRC_NETWORK, 16'h0002);
        {discrete_inputs_run, discrete_inputs_fwd, discrete_inputs_sel} = 3'h7;
        cyc(3);
        check(ctl.run_ramp, 16'h0001);
        check(ctl.forward, 16'h0001);
        discrete_inputs_run = 1'b0;
        cyc(3);
        check({ctl.coast, ctl.power_on}, 16'h0002);
        discrete_inputs_sel = 1'b0;
        $display("test stop done");
        // fault reset pulses only while faulted
        fault_latched = 1'b1;
        cyc(1);
        check(drive_state_word[15], 16'h0001);
        wr(SRC_NETWORK, 16'h0080);
        check(fault_reset, 16'h0001);
        fault_latched = 1'b0;
        cyc(1);
        check(fault_reset, 16'h0000);
        wr(SRC_NETWORK, 16'h0080);
        check(fault_reset, 16'h0000);
        $display("test fault done");
        for (int m = 0; m < 6; m++) begin
            cfg.motor_control_method = 3'(m);
            cyc(2);
            check({ctl.method_vf, ctl.method_qvf, ctl.sensorless_vector_mode, ctl.config_error},
                  {12'h000, m == 0, m == 1, m == 5, m > 1 && m < 5});
            check(drive_state_word[6], {15'h0000, m > 1 && m < 5});
        end
        // slip comp in regeneration, then filter pass-through and hold
        cfg.regen_slip_comp_enable = 1'b0;
        power_flow_to_drive = 1'b1;
        cyc(4);
        check(ctl.slip_comp_active, 16'h0000);
        power_flow_to_drive = 1'b0;
        cyc(4);
        check(ctl.slip_comp_active, 16'h0001);
        check(slip_comp_out, 16'h0089);
        check(total_current_filt, 16'h1234);
        check(active_current_filt, 16'h0567);
        {cfg.regen_slip_comp_enable, power_flow_to_drive} = 2'h3;
        cfg.current_filter_tau = 14'h01f4;
        total_current = 16'sh2000;
        cyc(10);
        check(ctl.slip_comp_active, 16'h0001);
        check(total_current_filt, 16'h1234);
        $display("test method done");
        finish_test();
    end
endmodule
`default_nettype wire
